// ---- rtl/dfp_top.sv ----
// Overview of operation
// - State query returns one byte, no state change
// - State byte matches status response state byte
// - Abort outside the error state returns to idle with status OK
// - Download uses class out type, code 1
// - Program start command padded to 32 bytes
// - Filler bytes, start modulo 32, are discarded
// - Trailing 16-byte suffix is never programmed
// - Zero-length download ends the image transfer
// - Flash read: read command then upload
// - Read command selects display or blank check
// - Display upload returns start through end bytes
// - Blank check status answered after scan finishes
// - Non-blank reports failure; upload returns address
// - Error state holds until clear-status request
// - Erase-check failure status encodes as 0x05
// - Idle state is 2, error is 10
`timescale 1ns/1ps
`include "dfp_cfg.svh"

module dfp_top
  import dfp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic setup_valid,
  input wire logic [7:0] req_type,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_length,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last,
  input wire logic in_ready,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_wr,
  output logic flash_rd,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_busy,
  output logic [7:0] state_field
);

  // ----------------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------------

  // Matches the setup fields against one request type and code.
  function automatic logic req_is(input logic [7:0] t, input logic [7:0] c);
    req_is = (req_type == t) && (req_code == c);
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  dfp_phase_type phase_reg, phase_next; // Sequencer phase.
  dfp_rdmode_type rd_mode_reg, rd_mode_next; // Pending upload content.
  logic [7:0] state_reg, state_next; // Protocol state byte.
  logic [7:0] status_reg, status_next; // Status byte for the next status query.
  logic session_reg, session_next; // A programming sequence is open.
  logic prog_done_reg, prog_done_next; // The end address was written.
  logic [4:0] fill_left_reg, fill_left_next; // Filler bytes still to drop.
  logic [15:0] prog_addr_reg, prog_addr_next; // Next address to program.
  logic [15:0] end_addr_reg, end_addr_next; // Last address to program.
  logic [15:0] rd_addr_reg, rd_addr_next; // Read pointer, or failing address.
  logic [15:0] rd_end_reg, rd_end_next; // Last address to read.
  logic [15:0] blk_left_reg, blk_left_next; // Bytes left in the download block.
  logic [2:0] byte_idx_reg, byte_idx_next; // Command bytes gathered.
  logic [7:0] cmd_reg [0:5]; // Gathered command bytes.
  logic [7:0] cmd_next [0:5];
  logic [7:0] resp_reg [0:5]; // Bytes of the pending short answer.
  logic [7:0] resp_next [0:5];
  logic [2:0] resp_len_reg, resp_len_next; // Length of the short answer.
  logic [2:0] resp_idx_reg, resp_idx_next; // Byte being offered.
  logic status_wait_reg, status_wait_next; // Status query parked during a scan.
  logic out_ready_reg, out_ready_next;
  logic in_valid_reg, in_valid_next;
  logic [7:0] in_data_reg, in_data_next;
  logic in_last_reg, in_last_next;
  logic [15:0] flash_addr_reg, flash_addr_next;
  logic [7:0] flash_wdata_reg, flash_wdata_next;
  logic flash_wr_reg, flash_wr_next;
  logic flash_rd_reg, flash_rd_next;

  logic accept; // A download byte is taken this cycle.
  logic take_idle; // A setup is taken this cycle.
  logic do_status; // Build the six-byte status answer.
  logic in_error; // The state byte says error.
  logic [7:0] after_state; // State reported in the status answer.

  assign accept = out_valid && out_ready_reg;
  assign take_idle = setup_valid && (phase_reg == PH_IDLE);
  assign in_error = (state_reg == `DFP_ST_ERROR);

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------

  // One process steps the whole sequencer; flash strobes are single pulses.
  always_comb begin
    phase_next = phase_reg;
    rd_mode_next = rd_mode_reg;
    state_next = state_reg;
    status_next = status_reg;
    session_next = session_reg;
    prog_done_next = prog_done_reg;
    fill_left_next = fill_left_reg;
    prog_addr_next = prog_addr_reg;
    end_addr_next = end_addr_reg;
    rd_addr_next = rd_addr_reg;
    rd_end_next = rd_end_reg;
    blk_left_next = blk_left_reg;
    byte_idx_next = byte_idx_reg;
    cmd_next = cmd_reg;
    resp_next = resp_reg;
    resp_len_next = resp_len_reg;
    resp_idx_next = resp_idx_reg;
    status_wait_next = status_wait_reg;
    in_valid_next = in_valid_reg;
    in_data_next = in_data_reg;
    in_last_next = in_last_reg;
    flash_addr_next = flash_addr_reg;
    flash_wdata_next = flash_wdata_reg;
    flash_wr_next = 1'b0;
    flash_rd_next = 1'b0;
    out_ready_next = 1'b0;
    do_status = 1'b0;
    after_state = state_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (setup_valid) begin
          if (req_is(`DFP_TYPE_IN, `DFP_REQ_GETSTATE)) begin
            // The live state byte is answered and left untouched.
            resp_next[0] = state_reg;
            resp_len_next = 3'h1;
            resp_idx_next = 3'h0;
            phase_next = PH_RESP;
          end else if (req_is(`DFP_TYPE_IN, `DFP_REQ_GETSTATUS)) begin
            do_status = 1'b1;
          end else if (req_is(`DFP_TYPE_OUT, `DFP_REQ_CLRSTATUS)) begin
            status_next = `DFP_STS_OK;
            state_next = `DFP_ST_IDLE;
          end else if (!in_error && req_code == `DFP_REQ_ABORT
              && (req_type == `DFP_TYPE_OUT || req_type == `DFP_TYPE_IN)) begin
            // Both printed type values are honoured for abort.
            session_next = 1'b0;
            rd_mode_next = RDM_NONE;
            status_next = `DFP_STS_OK;
            state_next = `DFP_ST_IDLE;
          end else if (req_is(`DFP_TYPE_OUT, `DFP_REQ_DNLOAD)) begin
            if (req_length == 16'h0000) begin
              // The empty block closes the image; an unfinished one is flagged.
              session_next = 1'b0;
              if (!in_error && session_reg && !prog_done_reg) begin
                status_next = `DFP_STS_NOTDONE;
              end else if (!in_error) begin
                state_next = `DFP_ST_IDLE;
              end
            end else begin
              blk_left_next = req_length;
              byte_idx_next = 3'h0;
              phase_next = PH_DATA;
            end
          end else if (req_is(`DFP_TYPE_IN, `DFP_REQ_UPLOAD)) begin
            // An upload answers only the command just before it.
            if (!in_error && rd_mode_reg == RDM_DISPLAY) begin
              state_next = `DFP_ST_UPIDLE;
              phase_next = PH_FETCH;
            end else if (rd_mode_reg == RDM_FAIL) begin
              resp_next[0] = rd_addr_reg[15:8];
              resp_next[1] = rd_addr_reg[7:0];
              resp_len_next = 3'h2;
              resp_idx_next = 3'h0;
              rd_mode_next = RDM_NONE;
              phase_next = PH_RESP;
            end
          end
        end
      end
      PH_DATA: begin
        // Ready drops for one cycle after each byte, two after a written byte, so flash_busy can rise.
        out_ready_next = !flash_busy && !accept && !flash_wr_reg;
        if (accept) begin
          blk_left_next = blk_left_reg - 16'h0001;
          if (in_error) begin
            // Data sent while in error is consumed and dropped.
          end else if (!session_reg) begin
            if (byte_idx_reg < `DFP_CMD_LEN) begin
              cmd_next[byte_idx_reg] = out_data;
              byte_idx_next = byte_idx_reg + 3'h1;
            end
          end else if (fill_left_reg != 5'h00) begin
            fill_left_next = fill_left_reg - 5'h01;
          end else if (!prog_done_reg) begin
            flash_wr_next = 1'b1;
            flash_addr_next = prog_addr_reg;
            flash_wdata_next = out_data;
            prog_addr_next = prog_addr_reg + 16'h0001;
            prog_done_next = (prog_addr_reg == end_addr_reg);
          end
          // Bytes past the end address are the suffix and are dropped.
          if (blk_left_reg == 16'h0001) begin
            out_ready_next = 1'b0;
            phase_next = (!session_reg && !in_error) ? PH_DECODE : PH_IDLE;
            if (session_reg && !in_error) begin
              state_next = `DFP_ST_DNIDLE;
            end
          end
        end
      end
      PH_DECODE: begin
        // The first payload byte names the command.
        phase_next = PH_IDLE;
        state_next = `DFP_ST_DNIDLE;
        rd_mode_next = RDM_NONE;
        if (cmd_reg[0] == `DFP_CMD_PROG && cmd_reg[1] == `DFP_SUB_PROG) begin
          session_next = 1'b1;
          prog_done_next = 1'b0;
          prog_addr_next = {cmd_reg[2], cmd_reg[3]};
          end_addr_next = {cmd_reg[4], cmd_reg[5]};
          fill_left_next = cmd_reg[3][`DFP_ALIGN_BITS-1:0];
        end else if (cmd_reg[0] == `DFP_CMD_READ && cmd_reg[1] == `DFP_SEL_DISPLAY) begin
          rd_mode_next = RDM_DISPLAY;
          rd_addr_next = {cmd_reg[2], cmd_reg[3]};
          rd_end_next = {cmd_reg[4], cmd_reg[5]};
        end else if (cmd_reg[0] == `DFP_CMD_READ && cmd_reg[1] == `DFP_SEL_BLANK) begin
          rd_addr_next = {cmd_reg[2], cmd_reg[3]};
          rd_end_next = {cmd_reg[4], cmd_reg[5]};
          status_wait_next = 1'b0;
          phase_next = PH_BLANK_RD;
        end else begin
          status_next = `DFP_STS_UNKNOWN;
        end
      end
      PH_BLANK_RD, PH_BLANK_WAIT, PH_BLANK_CHK: begin
        // A status query during the scan is parked, not answered.
        if (setup_valid && req_is(`DFP_TYPE_IN, `DFP_REQ_GETSTATUS)) begin
          status_wait_next = 1'b1;
        end
        if (phase_reg == PH_BLANK_RD) begin
          flash_rd_next = 1'b1;
          flash_addr_next = rd_addr_reg;
          phase_next = PH_BLANK_WAIT;
        end else if (phase_reg == PH_BLANK_WAIT) begin
          phase_next = PH_BLANK_CHK;
        end else if (flash_rdata != `DFP_ERASED || rd_addr_reg == rd_end_reg) begin
          if (flash_rdata != `DFP_ERASED) begin
            status_next = `DFP_STS_CHECK_ERASED;
            rd_mode_next = RDM_FAIL;
          end
          phase_next = PH_IDLE;
          do_status = status_wait_next;
        end else begin
          rd_addr_next = rd_addr_reg + 16'h0001;
          phase_next = PH_BLANK_RD;
        end
      end
      PH_FETCH: begin
        flash_rd_next = 1'b1;
        flash_addr_next = rd_addr_reg;
        phase_next = PH_FETCH_WAIT;
      end
      PH_FETCH_WAIT: begin
        phase_next = PH_CAPTURE;
      end
      PH_CAPTURE: begin
        in_valid_next = 1'b1;
        in_data_next = flash_rdata;
        in_last_next = (rd_addr_reg == rd_end_reg);
        phase_next = PH_SEND;
      end
      PH_SEND: begin
        if (in_ready) begin
          in_valid_next = 1'b0;
          in_last_next = 1'b0;
          if (in_last_reg) begin
            rd_mode_next = RDM_NONE;
            state_next = `DFP_ST_IDLE;
            phase_next = PH_IDLE;
          end else begin
            rd_addr_next = rd_addr_reg + 16'h0001;
            phase_next = PH_FETCH;
          end
        end
      end
      PH_RESP: begin
        // Short answers are offered one byte at a time from the buffer.
        if (in_valid_reg && in_ready) begin
          if (in_last_reg) begin
            in_valid_next = 1'b0;
            in_last_next = 1'b0;
            phase_next = PH_IDLE;
          end else begin
            resp_idx_next = resp_idx_reg + 3'h1;
            in_data_next = resp_reg[resp_idx_next];
            in_last_next = (resp_idx_next == resp_len_reg - 3'h1);
          end
        end else if (!in_valid_reg) begin
          in_valid_next = 1'b1;
          in_data_next = resp_reg[resp_idx_reg];
          in_last_next = (resp_idx_reg == resp_len_reg - 3'h1);
        end
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
    if (do_status) begin
      // Reporting an error status moves the state byte to error.
      after_state = (status_next != `DFP_STS_OK) ? `DFP_ST_ERROR : state_next;
      resp_next[0] = status_next;
      resp_next[1] = 8'h00;
      resp_next[2] = 8'h00;
      resp_next[3] = 8'h00;
      resp_next[4] = after_state;
      resp_next[5] = 8'h00;
      resp_len_next = `DFP_STATUS_LEN;
      resp_idx_next = 3'h0;
      status_wait_next = 1'b0;
      state_next = after_state;
      phase_next = PH_RESP;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------

  // All state, including every output, is registered here only.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= PH_IDLE;
      rd_mode_reg <= RDM_NONE;
      state_reg <= `DFP_ST_IDLE;
      status_reg <= `DFP_STS_OK;
      session_reg <= 1'b0;
      prog_done_reg <= 1'b0;
      fill_left_reg <= 5'h00;
      prog_addr_reg <= 16'h0000;
      end_addr_reg <= 16'h0000;
      rd_addr_reg <= 16'h0000;
      rd_end_reg <= 16'h0000;
      blk_left_reg <= 16'h0000;
      byte_idx_reg <= 3'h0;
      cmd_reg <= '{default: 8'h00};
      resp_reg <= '{default: 8'h00};
      resp_len_reg <= 3'h0;
      resp_idx_reg <= 3'h0;
      status_wait_reg <= 1'b0;
      out_ready_reg <= 1'b0;
      in_valid_reg <= 1'b0;
      in_data_reg <= 8'h00;
      in_last_reg <= 1'b0;
      flash_addr_reg <= 16'h0000;
      flash_wdata_reg <= 8'h00;
      flash_wr_reg <= 1'b0;
      flash_rd_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      rd_mode_reg <= rd_mode_next;
      state_reg <= state_next;
      status_reg <= status_next;
      session_reg <= session_next;
      prog_done_reg <= prog_done_next;
      fill_left_reg <= fill_left_next;
      prog_addr_reg <= prog_addr_next;
      end_addr_reg <= end_addr_next;
      rd_addr_reg <= rd_addr_next;
      rd_end_reg <= rd_end_next;
      blk_left_reg <= blk_left_next;
      byte_idx_reg <= byte_idx_next;
      cmd_reg <= cmd_next;
      resp_reg <= resp_next;
      resp_len_reg <= resp_len_next;
      resp_idx_reg <= resp_idx_next;
      status_wait_reg <= status_wait_next;
      out_ready_reg <= out_ready_next;
      in_valid_reg <= in_valid_next;
      in_data_reg <= in_data_next;
      in_last_reg <= in_last_next;
      flash_addr_reg <= flash_addr_next;
      flash_wdata_reg <= flash_wdata_next;
      flash_wr_reg <= flash_wr_next;
      flash_rd_reg <= flash_rd_next;
    end
  end

  assign out_ready = out_ready_reg;
  assign in_valid = in_valid_reg;
  assign in_data = in_data_reg;
  assign in_last = in_last_reg;
  assign flash_addr = flash_addr_reg;
  assign flash_wdata = flash_wdata_reg;
  assign flash_wr = flash_wr_reg;
  assign flash_rd = flash_rd_reg;
  assign state_field = state_reg;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_getstate_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    take_idle && req_is(`DFP_TYPE_IN, `DFP_REQ_GETSTATE) |-> ##2 in_valid_reg && in_last_reg
      && in_data_reg == $past(state_reg, 2)) else $error("state query answer wrong");
  a_getstate_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
    take_idle && req_is(`DFP_TYPE_IN, `DFP_REQ_GETSTATE) |=> $stable(state_reg))
    else $error("state query changed state");
  a_abort_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    take_idle && !in_error && req_code == `DFP_REQ_ABORT && (req_type == `DFP_TYPE_OUT || req_type == `DFP_TYPE_IN)
      |=> state_reg == `DFP_ST_IDLE && status_reg == `DFP_STS_OK && !session_reg)
    else $error("abort did not return to idle");
  a_clear_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    take_idle && req_is(`DFP_TYPE_OUT, `DFP_REQ_CLRSTATUS) |=> state_reg == `DFP_ST_IDLE
      && status_reg == `DFP_STS_OK) else $error("clear status did not reach idle");
  a_error_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    in_error && !(take_idle && req_is(`DFP_TYPE_OUT, `DFP_REQ_CLRSTATUS)) |=> in_error)
    else $error("error state left without clear");
  a_filler_dropped: assert property (@(posedge mclk) disable iff (!reset_n)
    accept && session_reg && !in_error && fill_left_reg != 5'h00 |=> !flash_wr_reg)
    else $error("filler byte was programmed");
  a_write_range: assert property (@(posedge mclk) disable iff (!reset_n)
    flash_wr_reg |-> flash_addr_reg <= end_addr_reg && flash_addr_reg == prog_addr_reg - 16'h0001)
    else $error("write outside programming range");
  a_zero_len_end: assert property (@(posedge mclk) disable iff (!reset_n)
    take_idle && req_is(`DFP_TYPE_OUT, `DFP_REQ_DNLOAD) && req_length == 16'h0000 |=> !session_reg)
    else $error("empty download did not close session");
  a_blank_fail: assert property (@(posedge mclk) disable iff (!reset_n)
    phase_reg == PH_BLANK_CHK && flash_rdata != `DFP_ERASED |=> status_reg == 8'h05
      && rd_mode_reg == RDM_FAIL) else $error("blank failure not reported");
  a_scan_silent: assert property (@(posedge mclk) disable iff (!reset_n)
    phase_reg == PH_BLANK_RD |-> ##1 !in_valid_reg [*2]) else $error("answer sent during scan");

endmodule

// ---- rtl/dfp_cfg.svh ----
`ifndef DFP_CFG_SVH
`define DFP_CFG_SVH

// ----------------------------------------------------------------------------
// Class request encodings
// ----------------------------------------------------------------------------
`define DFP_TYPE_OUT 8'h21
`define DFP_TYPE_IN 8'hA1
`define DFP_REQ_DNLOAD 8'h01
`define DFP_REQ_UPLOAD 8'h02
`define DFP_REQ_GETSTATUS 8'h03
`define DFP_REQ_CLRSTATUS 8'h04
`define DFP_REQ_GETSTATE 8'h05
`define DFP_REQ_ABORT 8'h06

// ----------------------------------------------------------------------------
// Command payload encodings
// ----------------------------------------------------------------------------
`define DFP_CMD_PROG 8'h01
`define DFP_CMD_READ 8'h03
`define DFP_SUB_PROG 8'h00
`define DFP_SEL_DISPLAY 8'h00
`define DFP_SEL_BLANK 8'h01
`define DFP_CMD_LEN 3'h6
`define DFP_ALIGN_BITS 5
`define DFP_ERASED 8'hFF

// ----------------------------------------------------------------------------
// State field and status field values
// ----------------------------------------------------------------------------
`define DFP_ST_IDLE 8'h02
`define DFP_ST_DNIDLE 8'h05
`define DFP_ST_UPIDLE 8'h09
`define DFP_ST_ERROR 8'h0A
`define DFP_STS_OK 8'h00
`define DFP_STS_CHECK_ERASED 8'h05
`define DFP_STS_NOTDONE 8'h09
`define DFP_STS_UNKNOWN 8'h0E
`define DFP_STATUS_LEN 3'h6

`endif

// ---- rtl/dfp_pkg.sv ----
package dfp_pkg;
  // Sequencer phases of the request handler.
  typedef enum logic [3:0] {
    PH_IDLE, PH_DATA, PH_DECODE, PH_RESP, PH_BLANK_RD, PH_BLANK_WAIT, PH_BLANK_CHK,
    PH_FETCH, PH_FETCH_WAIT, PH_CAPTURE, PH_SEND
  } dfp_phase_type;
  // What a following upload request returns.
  typedef enum logic [1:0] {RDM_NONE, RDM_DISPLAY, RDM_FAIL} dfp_rdmode_type;
endpackage

// ---- tb/dfp_flash_model.sv ----
`timescale 1ns/1ps
// Flash array behind the handler; a write keeps busy up for two cycles.
module dfp_flash_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_wr,
  input wire logic flash_rd,
  output logic [7:0] flash_rdata,
  output logic flash_busy
);
  logic [7:0] mem [0:255]; // Only the low address byte is decoded, to keep the model small.
  logic [1:0] busy_reg; // Busy cycles left of the current write.
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  assign flash_busy = busy_reg != 2'h0;
  // Read data is valid only in the cycle after a read; otherwise it toggles so a stale byte never passes.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg <= 2'h0;
      flash_rdata <= 8'h00;
    end else begin
      flash_rdata <= flash_rd ? mem[flash_addr[7:0]] : ~flash_rdata;
      if (flash_wr) begin
        mem[flash_addr[7:0]] <= flash_wdata;
        busy_reg <= 2'h2;
      end else if (busy_reg != 2'h0) begin
        busy_reg <= busy_reg - 2'h1;
      end
    end
  end
endmodule

// ---- tb/dfp_flash_program_read_tb.sv ----
`timescale 1ns/1ps
module dfp_flash_program_read_tb;
  logic mclk, reset_n, setup_valid, out_valid, in_ready, out_ready, in_valid, in_last, flash_wr, flash_rd, flash_busy;
  logic [7:0] req_type, req_code, out_data, in_data, flash_wdata, flash_rdata, state_field;
  logic [15:0] req_length, flash_addr;
  logic [7:0] bq[$]; // Payload of the next download block.
  logic [7:0] eq[$]; // Expected bytes of the next answer.
  logic [7:0] img[$]; // Every image file byte sent so far, for the suffix checksum.
  localparam logic [31:0] crc_poly = 32'hEDB8_8320; // Checksum polynomial; the handler ignores the result.
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  dfp_top i_dfp_top (.mclk, .reset_n, .setup_valid, .req_type, .req_code, .req_length, .out_valid, .out_data,
    .out_ready, .in_valid, .in_data, .in_last, .in_ready, .flash_addr, .flash_wdata, .flash_wr, .flash_rd,
    .flash_rdata, .flash_busy, .state_field);
  dfp_flash_model i_dfp_flash_model (.mclk, .reset_n, .flash_addr, .flash_wdata, .flash_wr, .flash_rd,
    .flash_rdata, .flash_busy);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // The whole run needs under a thousand cycles; a hang is cut off well beyond that.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Checksum over the image up to, but not including, its own field.
  function automatic logic [31:0] crc32(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (q[i]) begin
      c = c ^ {24'h00_0000, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ crc_poly) : (c >> 1);
    end
    return c;
  endfunction
  // Gaps of four cycles let the handler settle back to idle before each request.
  task automatic setup(input logic [7:0] t, input logic [7:0] c, input logic [15:0] len);
    repeat (4) @(posedge mclk);
    setup_valid <= 1'b1;
    req_type <= t;
    req_code <= c;
    req_length <= len;
    @(posedge mclk);
    setup_valid <= 1'b0;
  endtask
  task automatic dnload();
    setup(8'h21, 8'h01, 16'(bq.size()));
    foreach (bq[i]) begin
      out_valid <= 1'b1;
      out_data <= bq[i];
      do @(posedge mclk); while (out_ready !== 1'b1);
    end
    out_valid <= 1'b0;
    bq = {};
  endtask
  task automatic recv();
    in_ready <= 1'b1;
    foreach (eq[i]) begin
      do @(posedge mclk); while (in_valid !== 1'b1);
      check8(in_data, eq[i]);
      check8({7'h00, in_last}, {7'h00, i == eq.size() - 1});
    end
    in_ready <= 1'b0;
    eq = {};
  endtask
  task automatic status(input logic [7:0] s, input logic [7:0] st);
    setup(8'hA1, 8'h03, 16'h0006);
    eq = '{s, 8'h00, 8'h00, 8'h00, st, 8'h00};
    recv();
  endtask
  task automatic state_q(input logic [7:0] st);
    setup(8'hA1, 8'h05, 16'h0001);
    eq = '{st};
    recv();
    check8(state_field, st);
  endtask
  // Two state queries from idle answer the idle code and leave it standing.
  task automatic t_state_query();
    state_q(8'h02);
    state_q(8'h02);
  endtask
  // Program 23h..26h: command, three filler bytes, four data bytes, a full suffix, a jump, then close.
  task automatic t_program();
    logic [31:0] crc;
    bq = '{8'h01, 8'h00, 8'h00, 8'h23, 8'h00, 8'h26};
    repeat (26) bq.push_back(8'h00);
    img = bq;
    dnload();
    status(8'h00, 8'h05);
    bq = '{8'h00, 8'h00, 8'h00, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    bq = {bq, 8'h00, 8'h01, 8'h55, 8'h46, 8'h44, 8'h10};
    img = {img, bq};
    crc = crc32(img);
    bq = {bq, crc[7:0], crc[15:8], crc[23:16], crc[31:24]};
    dnload();
    status(8'h00, 8'h05);
    // The jump block arrives after the end address, so it is never programmed.
    bq = '{8'h04, 8'h03, 8'h01, 8'h00, 8'h00};
    dnload();
    status(8'h00, 8'h05);
    setup(8'h21, 8'h01, 16'h0000);
    state_q(8'h02);
    for (int a = 32; a < 40; a++) check8(i_dfp_flash_model.mem[a], (a > 34 && a < 39) ? 8'(a + 125) : 8'hFF);
  endtask
  // Display the programmed range; the state byte shows upload while it streams.
  task automatic t_display();
    bq = '{8'h03, 8'h00, 8'h00, 8'h23, 8'h00, 8'h26};
    dnload();
    status(8'h00, 8'h05);
    setup(8'hA1, 8'h02, 16'h0004);
    @(posedge mclk);
    check8(state_field, 8'h09);
    eq = '{8'hA0, 8'hA1, 8'hA2, 8'hA3};
    recv();
  endtask
  // Blank check over a range whose second byte is written.
  task automatic t_blank_fail();
    bq = '{8'h03, 8'h01, 8'h00, 8'h22, 8'h00, 8'h24};
    dnload();
    status(8'h05, 8'h0A);
    state_q(8'h0A);
    setup(8'h21, 8'h06, 16'h0000);
    state_q(8'h0A);
    setup(8'hA1, 8'h02, 16'h0002);
    eq = '{8'h00, 8'h23};
    recv();
    setup(8'h21, 8'h04, 16'h0000);
    state_q(8'h02);
  endtask
  // Blank range, then abort out of the download state.
  task automatic t_blank_abort();
    bq = '{8'h03, 8'h01, 8'h00, 8'h80, 8'h00, 8'h81};
    dnload();
    status(8'h00, 8'h05);
    setup(8'hA1, 8'h06, 16'h0000);
    state_q(8'h02);
  endtask
  // An unknown command, then an image closed before its end address was reached.
  task automatic t_bad_commands();
    bq = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    dnload();
    status(8'h0E, 8'h0A);
    setup(8'h21, 8'h04, 16'h0000);
    bq = '{8'h01, 8'h00, 8'h00, 8'h40, 8'h00, 8'h41};
    repeat (26) bq.push_back(8'h00);
    dnload();
    status(8'h00, 8'h05);
    setup(8'h21, 8'h01, 16'h0000);
    status(8'h09, 8'h0A);
  endtask
  initial begin
    {reset_n, setup_valid, out_valid, in_ready} <= 4'h0;
    {req_type, req_code, out_data, req_length} <= 40'h0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    check8(state_field, 8'h02);
    t_state_query();
    t_program();
    t_display();
    t_blank_fail();
    t_blank_abort();
    t_bad_commands();
    finish_test();
  end
endmodule
